//--- adc_seq_pkg.sv
/*
  Constants, field layouts and types for the converter sequencer.
  Assumes a single 25 MHz system clock and a plain strobed register port.
*/
package adc_seq_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  // pending request ages this long before the change notice is raised
  localparam int RATE_LIMIT_MS = 100;
  localparam int RATE_CYCLES = (CLK_HZ / 1000) * RATE_LIMIT_MS;
  localparam int RATE_W = 22;
  // fixed low time of a change pulse after an input edge
  localparam int PULSE_NS = 1000;
  localparam int PULSE_CYCLES = PULSE_NS / CLK_PERIOD_NS;
  localparam int PULSE_W = 5;
  localparam logic [PULSE_W-1:0] PULSE_LOAD = PULSE_W'(PULSE_CYCLES);
  localparam int SETTLE_COUNTS = 8;
  localparam logic [2:0] SETTLE_LAST = 3'(SETTLE_COUNTS - 1);

  // register byte addresses
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;

  // interrupt bit positions
  localparam int IRQ_DONE = 0;
  localparam int IRQ_CHANGE = 1;
  localparam int IRQ_NOTICE = 2;
  localparam int IRQ_W = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

  // synchroniser lanes
  localparam int SY_OWIN = 0;
  localparam int SY_UNLVL = 1;
  localparam int SY_OMD = 2;
  localparam int SY_LVLRD = 3;
  localparam int SY_STRD = 4;
  localparam int SY_BD = 5;
  localparam int SY_DETV = 6;
  localparam int SYNC_W = 7;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 7'h3f;

  typedef struct packed {
    logic free_run_request_n;
    logic req_suppress;
  } ctrl_s;
  localparam ctrl_s CTRL_RESET = '{free_run_request_n: 1'b1, req_suppress: 1'b0};

  typedef struct packed {
    logic board_present_n;
    logic overmod_n;
    logic unleveled_n;
    logic conv_service_req_n;
  } stat_s;

  typedef enum logic [2:0] {
    ST_STOP = 3'b001,
    ST_TRACK = 3'b010,
    ST_SETTLE = 3'b100
  } conv_state_e;
endpackage

//--- adc_conversion_sequencer.sv
/*
  Conversion sequencer: gates the tracking converter clock, raises the
  service request, the shared change notice and the status nibble.
  Assumes all pin inputs are asynchronous and the register port is
  driven on sys_clk_i.
*/
`timescale 1ns/1ns
// Overview of operation
// - outside-window error starts a conversion and enables the converter clock
// - clock stays stopped while input stays inside the window
// - outside-window input is active low
// - clock runs eight more pulses after the error enters the window
// - completion counter advances only while inside the window
// - eighth count reloads counter, stops the clock, clocks request latch
// - request latch captures suppress level; low suppress asserts request
// - at most one service notice per 100 ms
// - pending request holds clock off; level read clears it
// - notice goes low after request ages; released after level read
// - unleveled or overmod change pulses the change notice low
// - both edges pulse; pulse lasts a fixed time
// - status read places four status bits on the data bus
// - free-run request low runs clock; else conversion and detector valid
// - clock never runs during a level read
module adc_conversion_sequencer
#(
  parameter int RATE_LIMIT_CYCLES = adc_seq_pkg::RATE_CYCLES
)
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic irq_o,
  input wire logic outside_window_n_i,
  input wire logic unleveled_n_i,
  input wire logic overmod_n_i,
  input wire logic board_present_n_i,
  input wire logic detector_valid_i,
  input wire logic level_read_strobe_n_i,
  input wire logic status_read_strobe_n_i,
  output logic conv_clk_en_o,
  output logic conv_service_req_n_o,
  output logic change_notice_n_o,
  output adc_seq_pkg::stat_s stat_data_o,
  output logic stat_data_oe_o
);
  import adc_seq_pkg::*;

  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic [1:0] edge_prev_reg;
  conv_state_e state_reg;
  logic [2:0] settle_cnt_reg;
  logic srq_pend_reg;
  logic req_n_reg; // pin copy of the latch, so the pin leaves a flop
  logic [RATE_W-1:0] age_reg;
  logic srq_notice_reg;
  logic [PULSE_W-1:0] pulse_cnt_reg;
  logic change_n_reg;
  logic clk_en_reg;
  ctrl_s ctrl_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_stat_next;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic irq_reg;
  logic [31:0] rdata_reg;
  stat_s stat_reg;
  logic stat_oe_reg;

  logic outside;
  logic level_rd;
  logic term;
  logic in_edge;
  stat_s live_stat;
  logic [RATE_W-1:0] rate_last;

  assign rate_last = RATE_W'(RATE_LIMIT_CYCLES - 1);

  // two flops per pin; only the second stage is read
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      sync1_reg <= SYNC_RESET;
      sync2_reg <= SYNC_RESET;
    end
    else
    begin
      sync1_reg <= {detector_valid_i, board_present_n_i, status_read_strobe_n_i,
                    level_read_strobe_n_i, overmod_n_i, unleveled_n_i,
                    outside_window_n_i};
      sync2_reg <= sync1_reg;
    end
  end

  assign outside = !sync2_reg[SY_OWIN];
  assign level_rd = !sync2_reg[SY_LVLRD];

  // completion counter ends after eight in-window clock pulses
  assign term = (state_reg == ST_SETTLE) && !outside && clk_en_reg &&
                (settle_cnt_reg == SETTLE_LAST);

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= ST_STOP;
    end
    else
    begin
      case (state_reg)
        ST_STOP:
        begin
          if (outside)
          begin
            state_reg <= ST_TRACK;
          end
        end
        ST_TRACK:
        begin
          if (!outside)
          begin
            state_reg <= ST_SETTLE;
          end
        end
        ST_SETTLE:
        begin
          if (outside)
          begin
            state_reg <= ST_TRACK;
          end
          else if (term)
          begin
            state_reg <= ST_STOP;
          end
        end
        default:
        begin
          state_reg <= ST_STOP;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      settle_cnt_reg <= 3'h0;
    end
    else if (outside || term)
    begin
      settle_cnt_reg <= 3'h0;
    end
    else if (state_reg == ST_SETTLE && clk_en_reg)
    begin
      settle_cnt_reg <= settle_cnt_reg + 3'h1;
    end
  end

  // converter clock gate; a read beats free-run since the latch is frozen
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      clk_en_reg <= 1'b0;
    end
    else if (level_rd)
    begin
      clk_en_reg <= 1'b0;
    end
    else if (!ctrl_reg.free_run_request_n)
    begin
      clk_en_reg <= 1'b1;
    end
    else
    begin
      clk_en_reg <= (state_reg != ST_STOP) && !term && !srq_pend_reg &&
                    sync2_reg[SY_DETV];
    end
  end

  // request latch: a new completion wins over a same-cycle read clear
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      srq_pend_reg <= 1'b0;
      req_n_reg <= 1'b1;
    end
    else if (term && !ctrl_reg.req_suppress)
    begin
      srq_pend_reg <= 1'b1;
      req_n_reg <= 1'b0;
    end
    else if (level_rd)
    begin
      srq_pend_reg <= 1'b0;
      req_n_reg <= 1'b1;
    end
  end

  // request ageing sets the processor pace: one notice per rate window
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      age_reg <= '0;
      srq_notice_reg <= 1'b0;
    end
    else if (!srq_pend_reg)
    begin
      age_reg <= '0;
      srq_notice_reg <= 1'b0;
    end
    else if (age_reg == rate_last)
    begin
      srq_notice_reg <= 1'b1;
    end
    else
    begin
      age_reg <= age_reg + RATE_W'(1);
    end
  end

  assign in_edge = (edge_prev_reg != {sync2_reg[SY_OMD], sync2_reg[SY_UNLVL]});

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      edge_prev_reg <= 2'h3;
      pulse_cnt_reg <= '0;
    end
    else
    begin
      edge_prev_reg <= {sync2_reg[SY_OMD], sync2_reg[SY_UNLVL]};
      if (in_edge)
      begin
        pulse_cnt_reg <= PULSE_LOAD;
      end
      else if (pulse_cnt_reg != '0)
      begin
        pulse_cnt_reg <= pulse_cnt_reg - PULSE_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      change_n_reg <= 1'b1;
    end
    else
    begin
      change_n_reg <= !(in_edge || (pulse_cnt_reg > PULSE_W'(1)) ||
                        srq_notice_reg);
    end
  end

  assign live_stat = '{board_present_n: sync2_reg[SY_BD],
                       overmod_n: sync2_reg[SY_OMD],
                       unleveled_n: sync2_reg[SY_UNLVL],
                       conv_service_req_n: !srq_pend_reg};

  // status nibble stands on the bus while the strobe is low
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      stat_reg <= '1;
      stat_oe_reg <= 1'b0;
    end
    else
    begin
      stat_oe_reg <= !sync2_reg[SY_STRD];
      stat_reg <= sync2_reg[SY_STRD] ? stat_s'('1) : live_stat;
    end
  end

  always_comb
  begin
    irq_stat_next = irq_stat_reg;
    if (rd_i && addr_i == IRQ_STAT_OFS)
    begin
      irq_stat_next = '0;
    end
    // set after clear so an event in the read cycle survives
    irq_stat_next[IRQ_DONE] = irq_stat_next[IRQ_DONE] | term;
    irq_stat_next[IRQ_CHANGE] = irq_stat_next[IRQ_CHANGE] | in_edge;
    irq_stat_next[IRQ_NOTICE] = irq_stat_next[IRQ_NOTICE] |
                                (srq_pend_reg && age_reg == rate_last && !srq_notice_reg);
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      irq_stat_reg <= '0;
      irq_reg <= 1'b0;
    end
    else
    begin
      irq_stat_reg <= irq_stat_next;
      // a mask write gates the status in the same cycle it lands
      irq_reg <= |(irq_stat_next & ((wr_i && addr_i == IRQ_MASK_OFS) ?
                                    wdata_i[IRQ_W-1:0] : irq_mask_reg));
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_reg <= CTRL_RESET;
      irq_mask_reg <= IRQ_MASK_RESET;
    end
    else if (wr_i)
    begin
      if (addr_i == CTRL_OFS)
      begin
        ctrl_reg <= ctrl_s'(wdata_i[1:0]);
      end
      else if (addr_i == IRQ_MASK_OFS)
      begin
        irq_mask_reg <= wdata_i[IRQ_W-1:0];
      end
    end
  end

  // unmapped reads answer zero
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      rdata_reg <= '0;
    end
    else if (rd_i)
    begin
      if (addr_i == CTRL_OFS)
      begin
        rdata_reg <= {30'h0, ctrl_reg};
      end
      else if (addr_i == STATUS_OFS)
      begin
        rdata_reg <= {22'h0, state_reg, clk_en_reg, srq_notice_reg, !change_n_reg, live_stat};
      end
      else if (addr_i == IRQ_STAT_OFS)
      begin
        rdata_reg <= {29'h0, irq_stat_reg};
      end
      else if (addr_i == IRQ_MASK_OFS)
      begin
        rdata_reg <= {29'h0, irq_mask_reg};
      end
      else
      begin
        rdata_reg <= '0;
      end
    end
    else
    begin
      rdata_reg <= '0;
    end
  end

  assign rdata_o = rdata_reg;
  assign irq_o = irq_reg;
  assign conv_clk_en_o = clk_en_reg;
  assign conv_service_req_n_o = req_n_reg;
  assign change_notice_n_o = change_n_reg;
  assign stat_data_o = stat_reg;
  assign stat_data_oe_o = stat_oe_reg;

  AST_READ_STOPS: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    level_rd |=> !conv_clk_en_o) else $error("clock ran during level read");
  AST_FREE_RUN: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (!ctrl_reg.free_run_request_n && !level_rd) |=> conv_clk_en_o)
    else $error("free-run did not enable clock");
  AST_PEND_HOLD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (srq_pend_reg && ctrl_reg.free_run_request_n) |=> !conv_clk_en_o)
    else $error("clock ran with request pending");
  AST_TERM_STOP: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    term |=> (state_reg == ST_STOP && settle_cnt_reg == 3'h0))
    else $error("completion did not stop and reload");
  AST_REQ_SET: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (term && !ctrl_reg.req_suppress) |=> !conv_service_req_n_o)
    else $error("request not latched");
  AST_RELOAD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_reg == ST_SETTLE && outside) |=> (settle_cnt_reg == 3'h0 && state_reg == ST_TRACK))
    else $error("counter not reloaded on leaving window");
  AST_NOTICE_WAIT: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(srq_pend_reg) |-> !srq_notice_reg ##1 !srq_notice_reg)
    else $error("notice raised before request aged");
  AST_CHANGE_PULSE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (in_edge && !srq_notice_reg) |=> !change_notice_n_o ##1 !change_notice_n_o)
    else $error("no change pulse after input edge");
  AST_STATUS_BUS: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !sync2_reg[SY_STRD] |=> (stat_data_oe_o && stat_data_o == $past(live_stat)))
    else $error("status nibble not driven");
  AST_IRQ_LEVEL: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ##1 (irq_o == |(irq_stat_reg & irq_mask_reg))) else $error("interrupt level mismatch");
endmodule // adc_conversion_sequencer

//--- proc_model.sv
/*
  Processor model on the far side of the sequencer: read strobes only.
  Assumes the sequencer's outputs are registered on sys_clk_i.
*/
`timescale 1ns/1ns
module proc_model
(
  input wire logic sys_clk_i,
  input wire logic conv_service_req_n_i,
  input wire logic change_notice_n_i,
  input wire adc_seq_pkg::stat_s stat_data_i,
  input wire logic stat_data_oe_i,
  output logic level_read_strobe_n_o,
  output logic status_read_strobe_n_o
);
  import adc_seq_pkg::*;
  logic busy = 1'b0;
  initial
  begin
    level_read_strobe_n_o = 1'b1;
    status_read_strobe_n_o = 1'b1;
  end
  // strobe held several cycles so the synchronised copy is seen
  task automatic level_read(input int hold);
    busy = 1'b1;
    @(posedge sys_clk_i);
    level_read_strobe_n_o <= 1'b0;
    repeat (hold) @(posedge sys_clk_i);
    level_read_strobe_n_o <= 1'b1;
    @(posedge sys_clk_i);
    busy = 1'b0;
  endtask
  task automatic status_read(output stat_s d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    status_read_strobe_n_o <= 1'b0;
    @(posedge sys_clk_i);
    while (stat_data_oe_i !== 1'b1 && n < 8)
    begin
      n++;
      @(posedge sys_clk_i);
    end
    d = stat_data_i;
    status_read_strobe_n_o <= 1'b1;
  endtask
  // serves a pending request whenever the change notice is low, aged or not
  always @(posedge sys_clk_i)
    if (!busy && change_notice_n_i === 1'b0 && conv_service_req_n_i === 1'b0)
      level_read(6);
endmodule // proc_model

//--- adc_conversion_sequencer_test.sv
/*
  Self-checking bench for the conversion sequencer.
  Assumes proc_model drives both read strobes.
*/
`timescale 1ns/1ns
module adc_conversion_sequencer_test;
  import adc_seq_pkg::*;
  localparam int RATE = 20;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic own = 1'b1;
  logic unl = 1'b1;
  logic omd = 1'b1;
  logic bd = 1'b0;
  logic det = 1'b1;
  logic rd_seen = 1'b0;
  logic [31:0] rdata;
  logic irq, clk_en, req_n, notice_n, oe, lvl_n, st_n, acc;
  stat_s stat, s;
  logic [63:0] notes[$];
  logic [63:0] note;
  int seed = 32'h5d07;
  int bad_count = 0;
  int total_checks = 0;
  int n, k;
  always #20 sys_clk = ~sys_clk;
  adc_conversion_sequencer #(.RATE_LIMIT_CYCLES(RATE)) DUT
  (
    .sys_clk_i(sys_clk),
    .rst_n_i(rst_n),
    .addr_i(addr),
    .wdata_i(wdata),
    .wr_i(wr),
    .rd_i(rd),
    .rdata_o(rdata),
    .irq_o(irq),
    .outside_window_n_i(own),
    .unleveled_n_i(unl),
    .overmod_n_i(omd),
    .board_present_n_i(bd),
    .detector_valid_i(det),
    .level_read_strobe_n_i(lvl_n),
    .status_read_strobe_n_i(st_n),
    .conv_clk_en_o(clk_en),
    .conv_service_req_n_o(req_n),
    .change_notice_n_o(notice_n),
    .stat_data_o(stat),
    .stat_data_oe_o(oe)
  );
  proc_model PROC
  (
    .sys_clk_i(sys_clk),
    .conv_service_req_n_i(req_n),
    .change_notice_n_i(notice_n),
    .stat_data_i(stat),
    .stat_data_oe_i(oe),
    .level_read_strobe_n_o(lvl_n),
    .status_read_strobe_n_o(st_n)
  );
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    notes.push_back({m, e});
    @(posedge sys_clk);
    rd <= 1'b0;
  endtask
  task automatic settle(input int c);
    repeat (c) @(negedge sys_clk);
  endtask
  // a bounce back outside must restart the settle count
  task automatic convert(input bit bounce);
    @(posedge sys_clk);
    own <= 1'b0;
    settle(6 + ($random(seed) & 7));
    chk(32'(clk_en), 32'h1);
    @(posedge sys_clk);
    own <= 1'b1;
    if (bounce)
    begin
      repeat (4) @(posedge sys_clk);
      own <= 1'b0;
      repeat (3) @(posedge sys_clk);
      own <= 1'b1;
    end
    n = 0;
    @(negedge sys_clk);
    while (clk_en === 1'b1 && n < 40)
    begin
      n++;
      @(negedge sys_clk);
    end
    // two sync stages and the window entry cycle precede the eight counts
    chk(n, 3 + SETTLE_COUNTS);
  endtask
  always @(posedge sys_clk)
    rd_seen <= rd;
  always @(negedge sys_clk)
    if (rd_seen && notes.size() > 0)
    begin
      note = notes.pop_front();
      chk(rdata & note[63:32], note[31:0]);
    end
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    print_verdict();
  end
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd_reg(CTRL_OFS, 32'h3, 32'h2);
    rd_reg(IRQ_MASK_OFS, 32'h7, 32'h0);
    wr_reg(8'h10, 32'hffffffff);
    wr_reg(STATUS_OFS, 32'h0);
    rd_reg(8'h10, 32'hffffffff, 32'h0);
    rd_reg(CTRL_OFS, 32'h3, 32'h2);
    wr_reg(IRQ_MASK_OFS, 32'h7);
    rd_reg(IRQ_MASK_OFS, 32'h7, 32'h7);
    $display("test registers done");
    convert(1'b0);
    k = 0;
    while (req_n !== 1'b0 && k < 6)
    begin
      k++;
      @(negedge sys_clk);
    end
    chk(32'(req_n), 32'h0);
    @(posedge sys_clk);
    own <= 1'b0;
    acc = 1'b0;
    repeat (8)
    begin
      @(negedge sys_clk);
      acc = acc | clk_en;
    end
    chk(32'(acc), 32'h0);
    chk(32'(irq), 32'h1);
    @(posedge sys_clk);
    own <= 1'b1;
    k = 9 + k;
    while (notice_n !== 1'b0 && k < 80)
    begin
      k++;
      @(negedge sys_clk);
    end
    chk(32'(k >= RATE), 32'h1);
    chk(32'(notice_n), 32'h0);
    k = 0;
    while (req_n !== 1'b1 && k < 20)
    begin
      k++;
      @(negedge sys_clk);
    end
    chk(32'(req_n), 32'h1);
    settle(4);
    chk(32'(notice_n), 32'h1);
    settle(80);
    rd_reg(IRQ_STAT_OFS, 32'h5, 32'h5);
    rd_reg(IRQ_STAT_OFS, 32'h5, 32'h0);
    $display("test conversion done");
    wr_reg(CTRL_OFS, 32'h3);
    convert(1'b1);
    settle(30);
    chk(32'(req_n), 32'h1);
    wr_reg(CTRL_OFS, 32'h0);
    settle(3);
    chk(32'(clk_en), 32'h1);
    fork
      PROC.level_read(8);
      begin
        settle(6);
        chk(32'(clk_en), 32'h0);
      end
    join
    wr_reg(CTRL_OFS, 32'h3);
    settle(3);
    chk(32'(clk_en), 32'h0);
    @(posedge sys_clk);
    det <= 1'b0;
    own <= 1'b0;
    settle(8);
    chk(32'(clk_en), 32'h0);
    @(posedge sys_clk);
    det <= 1'b1;
    own <= 1'b1;
    settle(6);
    chk(32'(clk_en), 32'h1);
    settle(12);
    $display("test clock control done");
    wr_reg(IRQ_MASK_OFS, 32'h0);
    rd_reg(IRQ_STAT_OFS, 32'h0, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge sys_clk);
      if (i % 2 == 1)
        omd <= ~omd;
      else
        unl <= ~unl;
      bd <= 1'($random(seed));
      k = 0;
      while (notice_n !== 1'b0 && k < 8)
      begin
        k++;
        @(negedge sys_clk);
      end
      n = 0;
      while (notice_n === 1'b0 && n < 60)
      begin
        n++;
        @(negedge sys_clk);
      end
      chk(n, PULSE_CYCLES);
      chk(32'(irq), 32'h0);
      PROC.status_read(s);
      chk(32'(oe), 32'h1);
      chk(32'(s), 32'({bd, omd, unl, 1'b1}));
    end
    wr_reg(IRQ_MASK_OFS, 32'h7);
    settle(3);
    chk(32'(irq), 32'h1);
    rd_reg(IRQ_STAT_OFS, 32'h2, 32'h2);
    settle(3);
    chk(32'(irq), 32'h0);
    $display("test change pulses done");
    print_verdict();
  end
endmodule // adc_conversion_sequencer_test
